// [pkg/sc_pkg.sv]
// constants and types shared by the supply controller register block
package sc_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0] OFF_CMD      = 6'h00;
  localparam logic [5:0] OFF_SMCFG    = 6'h04;
  localparam logic [5:0] OFF_MODE     = 6'h08;
  localparam logic [5:0] OFF_WUMODE   = 6'h0c;
  localparam logic [5:0] OFF_WUIN     = 6'h10;
  localparam logic [5:0] OFF_STAT     = 6'h14;
  localparam logic [5:0] OFF_RSVD     = 6'h18;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h20;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h24;

  // ****************************************
  // fields
  // ****************************************
  localparam int         KEY_LSB       = 24;
  localparam logic [7:0] KEY_VAL       = 8'ha5;
  localparam int         CMD_STOP_BIT  = 2;
  localparam int         CMD_XTAL_BIT  = 3;
  localparam int         SM_TH_LSB     = 0;
  localparam int         SM_SMPL_LSB   = 8;
  localparam int         SM_RST_BIT    = 12;
  localparam int         SM_IRQ_BIT    = 13;
  localparam int         MD_BODRST     = 12;
  localparam int         MD_BOD_OFF    = 13;
  localparam int         MD_REG_USE    = 14;
  localparam int         MD_BYP        = 20;
  localparam int         WU_SMWAKE     = 1;
  localparam int         ST_STOP       = 0;
  localparam int         ST_BOD        = 3;
  localparam int         ST_SMOUT      = 5;
  localparam int         ST_OSCSEL     = 7;
  localparam int         IRQ_SM        = 0;
  localparam int         IRQ_BOD       = 1;
  localparam int         IRQ_W         = 2;

  // ****************************************
  // writable masks and reset values
  // ****************************************
  localparam logic [31:0] SMCFG_MASK  = 32'h0000_370f;
  localparam logic [31:0] MODE_MASK   = 32'h0010_7a00;
  localparam logic [31:0] WUMODE_MASK = 32'h0007_77ef;
  localparam logic [31:0] WUIN_MASK   = 32'hffff_ffff;
  localparam logic [31:0] SMCFG_RST   = 32'h0000_0000;
  localparam logic [31:0] MODE_RST    = 32'h0000_5a00;
  localparam logic [31:0] WU_RST      = 32'h0000_0000;

  // ****************************************
  // sampling codes and duty periods
  // ****************************************
  typedef enum logic [2:0] {
    SMPL_OFF  = 3'h0,
    SMPL_CONT = 3'h1,
    SMPL_32   = 3'h2,
    SMPL_256  = 3'h3,
    SMPL_2048 = 3'h4
  } sc_smpl_t;
  localparam logic [10:0] LIM_32   = 11'h01f;
  localparam logic [10:0] LIM_256  = 11'h0ff;
  localparam logic [10:0] LIM_2048 = 11'h7ff;

  // regulator shutdown sequence
  typedef enum logic [1:0] {
    VR_RUN = 2'b00,
    VR_RST = 2'b01,
    VR_OFF = 2'b11
  } sc_vr_t;

endpackage : sc_pkg

// [pkg/sc_duty_if.sv]
// carrier between register logic and the monitor duty counter
`timescale 1ns/1ps
interface sc_duty_if;
  logic [2:0] smpl;
  logic       restart;
  logic       en;
  modport ctl  (output smpl, output restart, input en);
  modport duty (input smpl, input restart, output en);
endinterface : sc_duty_if

// [src/sc_duty.sv]
// duty-cycled supply monitor enable from a slow-clock counter
`timescale 1ns/1ps
module sc_duty
  import sc_pkg::*;
(
  // clock, reset, enable
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // slow clock period strobe
  input  wire logic slow_tick,
  // control
  sc_duty_if.duty   dif
);
  logic [10:0] cnt_ff;
  logic [10:0] lim;

  always_comb
  begin
    case (dif.smpl)
      SMPL_32:   lim = LIM_32;
      SMPL_256:  lim = LIM_256;
      default:   lim = LIM_2048;
    endcase
  end

  // period restarts on any rewrite of the field
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_ff <= 11'h000;
    else if (ce)
    begin
      if (dif.restart) // R17
        cnt_ff <= 11'h000;
      else if (slow_tick)
        cnt_ff <= (cnt_ff == lim) ? 11'h000 : cnt_ff + 11'h001;
    end
  end

  // on throughout for SMPL_CONT; in the duty modes, on for the one slow period where the count is zero
  assign dif.en = (dif.smpl == SMPL_CONT) ||
                  ((dif.smpl == SMPL_32 || dif.smpl == SMPL_256 ||
                    dif.smpl == SMPL_2048) && cnt_ff == 11'h000); // R5

  a_duty_off: assert property (@(posedge clk) disable iff (!arst_n)
    dif.smpl == SMPL_OFF |-> !dif.en) // R5
    else $error("monitor enabled while sampling off");
  a_duty_restart: assert property (@(posedge clk) disable iff (!arst_n)
    ce && dif.restart |=> cnt_ff == 11'h000) // R17
    else $error("duty counter not restarted");
  a_duty_32: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !dif.restart && slow_tick && dif.smpl == SMPL_32 &&
    cnt_ff == LIM_32 |=> dif.smpl != SMPL_32 || dif.en) // R5
    else $error("duty period of 32 not honoured");
endmodule : sc_duty

// [src/sc_sticky.sv]
// sticky event flags, set wins over a write-one clear
`timescale 1ns/1ps
module sc_sticky #(
  parameter int W = 2
) (
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic [W-1:0]      q
);
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q_ff <= '0;
    else if (ce)
      q_ff <= (q_ff & ~clr) | set;
  end
  assign q = q_ff;

  a_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
    ce && (|set) |=> (q & $past(set)) == $past(set))
    else $error("event lost against clear");
endmodule : sc_sticky

// [src/sc_top.sv]
// supply controller register block: commands, monitor and mode control
//
// Overview of operation
// R1: while write protection is on, writes to command, monitor and mode registers are dropped.
// R2: a command or mode write whose top byte is not the password is dropped whole.
// R3: writing regulator-off as one asserts core reset and then stops the regulator.
// R4: writing crystal-select as one moves the slow clock to the crystal; zero does nothing.
// R5: sampling code picks off, continuous, or one slow period in 32, 256 or 2048.
// R6: the threshold field goes straight out as the monitor voltage code.
// R7: with monitor reset enable set, a monitor detection asserts core reset.
// R8: with monitor interrupt enable set, a monitor detection raises the interrupt; here irq also needs mask bit IRQ_SM set.
// R9: with brownout reset enable set, a brownout detection asserts core reset.
// R10: the brownout detector runs while brownout-disable is zero.
// R11: the regulator-use bit drives the internal regulator use control.
// R12: bypass selects the crystal in bypass mode, else crystal-select decides.
// R13: registers decode at 0x00 to 0x14, with 0x18 reserved.
// R14: command, brownout, regulator and bypass bits live in the backup domain.
// R15: with monitor wake enable set, a monitor detection starts a core wake-up.
// R16: the command register and reserved bits read zero and ignore writes.
// R17: the duty counter restarts whenever the sampling field is rewritten.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module sc_top
  import sc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // system inputs
  input  wire logic        write_protect_enable,
  input  wire logic        slow_tick,
  // analog detectors
  input  wire logic        monitor_detect,
  input  wire logic        brownout_detect,
  // supply controls
  output logic             core_reset_n,
  output logic             regulator_off,
  output logic             slow_xtal_sel,
  output logic             slow_osc_bypass,
  output logic [3:0]       monitor_threshold,
  output logic             monitor_enable,
  output logic             brownout_enable,
  output logic             internal_regulator_use,
  output logic             monitor_wake,
  output logic             irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic             ack_ff;
  logic             acc;
  logic             wr_go;
  logic             wr_ok;
  logic             key_ok;
  logic [5:0]       wa;
  logic [31:0]      bm;
  logic [31:0]      smcfg_ff;
  logic [31:0]      mode_ff;
  logic [31:0]      wumode_ff;
  logic [31:0]      wuin_ff;
  logic [31:0]      rdata_ff;
  logic [31:0]      nxt_rdata;
  logic [31:0]      stat;
  logic             xtal_ff;
  sc_vr_t           vr_ff;
  sc_vr_t           nxt_vr;
  logic             cmd_ok;
  logic             cmd_stop;
  logic             cmd_xtal;
  logic             sm_det;
  logic             bod_det;
  logic             sm_prev_ff;
  logic             bod_prev_ff;
  logic             sm_ev;
  logic             bod_ev;
  logic             rst_req;
  logic             core_rst_n_ff;
  logic             wake_ff;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff;

  sc_duty_if dif ();

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] m
  );
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // ****************************************
  // bus slave
  // ****************************************
  // one wait state so read data always comes from a flop
  assign acc             = (avs_read | avs_write) & ~ack_ff;
  assign avs_waitrequest = acc;
  assign wr_go           = ce & avs_write & ack_ff;
  assign wa              = {avs_address[5:2], 2'b00};
  assign bm              = {{8{avs_byteenable[3]}},
                            {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}},
                            {8{avs_byteenable[0]}}};
  assign wr_ok  = wr_go & ~write_protect_enable; // R1
  assign key_ok = avs_byteenable[3] &&
                  avs_writedata[KEY_LSB +: 8] == KEY_VAL; // R2

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_ff <= 1'b0;
    else if (ce)
      ack_ff <= acc;
  end

  always_comb
  begin
    case (wa) // R13
      OFF_SMCFG:    nxt_rdata = smcfg_ff;
      OFF_MODE:     nxt_rdata = mode_ff;
      OFF_WUMODE:   nxt_rdata = wumode_ff;
      OFF_WUIN:     nxt_rdata = wuin_ff;
      OFF_STAT:     nxt_rdata = stat;
      OFF_IRQ_STAT: nxt_rdata = 32'(irq_stat);
      OFF_IRQ_MASK: nxt_rdata = 32'(irq_mask_ff);
      default:      nxt_rdata = 32'h0000_0000; // R16
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_ff <= 32'h0000_0000;
    else if (ce && acc && avs_read)
      rdata_ff <= nxt_rdata;
  end
  assign avs_readdata = rdata_ff;

  // ****************************************
  // configuration registers
  // ****************************************
  // masks keep reserved bits at zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      smcfg_ff <= SMCFG_RST;
    else if (wr_ok && wa == OFF_SMCFG) // R1
      smcfg_ff <= merge(smcfg_ff, avs_writedata, bm & SMCFG_MASK); // R16
  end

  // backup-domain bits: only the always-on reset clears them
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_ff <= MODE_RST;
    else if (wr_ok && key_ok && wa == OFF_MODE) // R2
      mode_ff <= merge(mode_ff, avs_writedata, bm & MODE_MASK); // R14
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wumode_ff <= WU_RST;
      wuin_ff   <= WU_RST;
    end
    else if (wr_ok)
    begin
      if (wa == OFF_WUMODE)
        wumode_ff <= merge(wumode_ff, avs_writedata, bm & WUMODE_MASK);
      if (wa == OFF_WUIN)
        wuin_ff <= merge(wuin_ff, avs_writedata, bm & WUIN_MASK);
    end
  end

  // ****************************************
  // command register
  // ****************************************
  assign cmd_ok    = wr_ok & key_ok & (wa == OFF_CMD); // R2
  assign cmd_stop  = cmd_ok & avs_byteenable[0] &
                     avs_writedata[CMD_STOP_BIT];
  assign cmd_xtal  = cmd_ok & avs_byteenable[0] &
                     avs_writedata[CMD_XTAL_BIT];

  // the switch is one-way; only the backup reset undoes it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      xtal_ff <= 1'b0;
    else if (ce && cmd_xtal) // R4
      xtal_ff <= 1'b1; // R14
  end

  always_comb
  begin
    nxt_vr = vr_ff;
    case (vr_ff)
      VR_RUN:
      begin
        if (cmd_stop) // R3
          nxt_vr = VR_RST;
      end
      VR_RST:  nxt_vr = VR_OFF;
      VR_OFF:  nxt_vr = VR_OFF;
      default: nxt_vr = VR_RUN;
    endcase
  end

  // core reset goes first, regulator stops one cycle later
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      vr_ff <= VR_RUN;
    else if (ce)
      vr_ff <= nxt_vr; // R14
  end
  assign regulator_off = (vr_ff == VR_OFF); // R3

  // ****************************************
  // monitor and brownout
  // ****************************************
  assign dif.smpl    = smcfg_ff[SM_SMPL_LSB +: 3];
  assign dif.restart = wr_ok && wa == OFF_SMCFG; // R17

  sc_duty u_duty (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .slow_tick (slow_tick),
    .dif       (dif)
  );

  assign monitor_enable    = dif.en; // R5
  assign monitor_threshold = smcfg_ff[SM_TH_LSB +: 4]; // R6
  assign brownout_enable   = ~mode_ff[MD_BOD_OFF]; // R10
  assign internal_regulator_use = mode_ff[MD_REG_USE]; // R11
  assign slow_osc_bypass   = mode_ff[MD_BYP]; // R12
  assign slow_xtal_sel     = mode_ff[MD_BYP] | xtal_ff; // R12

  // a detector output is ignored while its detector is off
  assign sm_det  = monitor_detect & dif.en;
  assign bod_det = brownout_detect & brownout_enable;
  assign sm_ev   = sm_det & ~sm_prev_ff;
  assign bod_ev  = bod_det & ~bod_prev_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sm_prev_ff  <= 1'b0;
      bod_prev_ff <= 1'b0;
    end
    else if (ce)
    begin
      sm_prev_ff  <= sm_det;
      bod_prev_ff <= bod_det;
    end
  end

  assign rst_req = (nxt_vr != VR_RUN) // R3
                 | (sm_det & smcfg_ff[SM_RST_BIT]) // R7
                 | (bod_det & mode_ff[MD_BODRST]); // R9

  // core held in reset while the controller itself resets
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      core_rst_n_ff <= 1'b0;
    else if (ce)
      core_rst_n_ff <= ~rst_req;
  end
  assign core_reset_n = core_rst_n_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wake_ff <= 1'b0;
    else if (ce)
      wake_ff <= sm_ev & wumode_ff[WU_SMWAKE]; // R15
  end
  assign monitor_wake = wake_ff;

  // ****************************************
  // status and interrupt
  // ****************************************
  always_comb
  begin
    stat             = 32'h0000_0000;
    stat[ST_STOP]    = (vr_ff != VR_RUN);
    stat[ST_BOD]     = bod_det;
    stat[ST_SMOUT]   = sm_det;
    stat[ST_OSCSEL]  = slow_xtal_sel;
  end

  assign irq_set[IRQ_SM]  = sm_ev & smcfg_ff[SM_IRQ_BIT]; // R8
  assign irq_set[IRQ_BOD] = bod_ev;
  assign irq_clr = (wr_go && wa == OFF_IRQ_STAT && avs_byteenable[0]) ?
                   avs_writedata[IRQ_W-1:0] : '0;

  sc_sticky #(.W(IRQ_W)) u_irq (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .set    (irq_set),
    .clr    (irq_clr),
    .q      (irq_stat)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask_ff <= '0;
    else if (wr_go && wa == OFF_IRQ_MASK && avs_byteenable[0])
      irq_mask_ff <= avs_writedata[IRQ_W-1:0];
  end
  assign irq = |(irq_stat & irq_mask_ff); // R8

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_wp_mode: assert property ( // R1
    wr_go && write_protect_enable |=> $stable(mode_ff) && $stable(smcfg_ff))
    else $error("protected write changed a register");
  a_key_bad: assert property ( // R2
    wr_go && !key_ok && wa == OFF_MODE |=> $stable(mode_ff))
    else $error("mode written with wrong key");
  a_stop_seq: assert property ( // R3
    ce && cmd_stop && vr_ff == VR_RUN |=> !core_reset_n ##0
    !regulator_off ##1 ce [*1] ##0 regulator_off)
    else $error("regulator stop sequence wrong");
  a_xtal_sel: assert property ( // R4
    ce && cmd_xtal |=> slow_xtal_sel [*3])
    else $error("crystal not selected after command");
  a_thresh_src: assert property ( // R6
    $changed(monitor_threshold) |-> $past(wr_ok) &&
    $past(wa) == OFF_SMCFG)
    else $error("threshold changed without a write");
  a_mon_rst: assert property ( // R7
    ce && sm_det && smcfg_ff[SM_RST_BIT] |=> !core_reset_n)
    else $error("monitor detection did not reset core");
  a_mon_irq: assert property ( // R8
    ce && sm_ev && smcfg_ff[SM_IRQ_BIT] && irq_mask_ff[IRQ_SM]
    && $stable(irq_mask_ff) |=> irq_stat[IRQ_SM] && irq)
    else $error("monitor interrupt missing");
  a_bod_rst: assert property ( // R9
    ce && bod_det && mode_ff[MD_BODRST] |=> !core_reset_n)
    else $error("brownout did not reset core");
  a_bod_quiet: assert property ( // R9
    ce && !rst_req |=> core_reset_n)
    else $error("core reset without cause");
  a_wake_sm: assert property ( // R15
    ce && sm_ev && wumode_ff[WU_SMWAKE] |=> monitor_wake ##1 !monitor_wake
    || $past(sm_ev))
    else $error("monitor wake pulse wrong");
  a_wait_one: assert property (
    ce && acc ##1 ce |-> !avs_waitrequest)
    else $error("slave answered late");
  a_rsvd_read: assert property ( // R16
    ce && acc && avs_read && (wa == OFF_CMD || wa == OFF_RSVD)
    |=> avs_readdata == 32'h0000_0000)
    else $error("reserved read not zero");

endmodule : sc_top

// [verif/tb_top.sv]
// self-checking bench for the supply controller register block
`timescale 1ns/1ps
module tb_top;
  import sc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        clk;
  logic        arst_n;
  logic        ce;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        write_protect_enable;
  logic        slow_tick;
  logic        monitor_detect;
  logic        brownout_detect;
  logic        core_reset_n;
  logic        regulator_off;
  logic        slow_xtal_sel;
  logic        slow_osc_bypass;
  logic [3:0]  monitor_threshold;
  logic        monitor_enable;
  logic        brownout_enable;
  logic        internal_regulator_use;
  logic        monitor_wake;
  logic        irq;
  logic [3:0]  be_sel;
  int          error_cnt;
  int          total_checks;

  sc_top dut (
    .clk(clk), .arst_n(arst_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .write_protect_enable(write_protect_enable), .slow_tick(slow_tick),
    .monitor_detect(monitor_detect), .brownout_detect(brownout_detect),
    .core_reset_n(core_reset_n), .regulator_off(regulator_off),
    .slow_xtal_sel(slow_xtal_sel), .slow_osc_bypass(slow_osc_bypass),
    .monitor_threshold(monitor_threshold),
    .monitor_enable(monitor_enable), .brownout_enable(brownout_enable),
    .internal_regulator_use(internal_regulator_use),
    .monitor_wake(monitor_wake), .irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk32(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk32

  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= d;
    avs_byteenable <= be_sel;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20) chk1("bus answer", 1'b0, 1'b1);
    q = avs_readdata;
    avs_write      <= 1'b0;
    avs_read       <= 1'b0;
    avs_byteenable <= 4'hf;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string n, input logic [5:0] a,
                        input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk32(n, e, q);
  endtask : rd_chk

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk("smcfg", OFF_SMCFG, SMCFG_RST);
    rd_chk("mode", OFF_MODE, MODE_RST);
    rd_chk("status", OFF_STAT, 32'h0000_0000);
    rd_chk("command", OFF_CMD, 32'h0000_0000);
    rd_chk("reserved", OFF_RSVD, 32'h0000_0000);
    chk1("brownout_enable", 1'b1, brownout_enable);
    chk1("internal_regulator_use", 1'b1, internal_regulator_use);
    chk1("core_reset_n", 1'b1, core_reset_n);
  endtask : t_reset

  task automatic t_protect;
    @(posedge clk);
    write_protect_enable <= 1'b1;
    wr(OFF_SMCFG, 32'h0000_3105);
    wr(OFF_MODE, 32'ha510_7000);
    wr(OFF_CMD, 32'ha500_0008);
    rd_chk("smcfg", OFF_SMCFG, 32'h0000_0000);
    rd_chk("mode", OFF_MODE, MODE_RST);
    chk1("slow_xtal_sel", 1'b0, slow_xtal_sel);
    @(posedge clk);
    write_protect_enable <= 1'b0;
  endtask : t_protect

  task automatic t_mode;
    wr(OFF_MODE, 32'h3c10_7000);
    rd_chk("mode bad key", OFF_MODE, MODE_RST);
    be_sel = 4'h7;
    wr(OFF_MODE, 32'ha510_7000);
    be_sel = 4'hf;
    rd_chk("mode no key lane", OFF_MODE, MODE_RST);
    // reserved low byte written as ones must not stick
    wr(OFF_MODE, 32'ha510_70ff);
    rd_chk("mode", OFF_MODE, 32'h0010_7000);
    chk1("slow_osc_bypass", 1'b1, slow_osc_bypass);
    chk1("slow_xtal_sel", 1'b1, slow_xtal_sel);
    chk1("brownout_enable", 1'b0, brownout_enable);
    chk1("internal_regulator_use", 1'b1, internal_regulator_use);
    wr(OFF_MODE, 32'ha500_1000);
    rd_chk("mode", OFF_MODE, 32'h0000_1000);
    chk1("slow_osc_bypass", 1'b0, slow_osc_bypass);
    chk1("slow_xtal_sel", 1'b0, slow_xtal_sel);
    chk1("brownout_enable", 1'b1, brownout_enable);
    chk1("internal_regulator_use", 1'b0, internal_regulator_use);
  endtask : t_mode

  task automatic t_monitor;
    wr(OFF_IRQ_MASK, 32'h0000_0001);
    wr(OFF_SMCFG, 32'h0000_310a);
    rd_chk("smcfg", OFF_SMCFG, 32'h0000_310a);
    chk32("threshold", 32'h0000_000a, {28'h0, monitor_threshold});
    chk1("monitor_enable", 1'b1, monitor_enable);
    @(posedge clk);
    monitor_detect <= 1'b1;
    wait_n(2);
    chk1("core_reset_n", 1'b0, core_reset_n);
    chk1("irq", 1'b1, irq);
    @(posedge clk);
    monitor_detect <= 1'b0;
    wait_n(2);
    chk1("core_reset_n", 1'b1, core_reset_n);
    rd_chk("irq status", OFF_IRQ_STAT, 32'h0000_0001);
    wr(OFF_IRQ_STAT, 32'h0000_0001);
    wait_n(1);
    chk1("irq", 1'b0, irq);
    wr(OFF_SMCFG, 32'h0000_0100);
    @(posedge clk);
    monitor_detect <= 1'b1;
    wait_n(2);
    chk1("core_reset_n", 1'b1, core_reset_n);
    chk1("irq", 1'b0, irq);
    @(posedge clk);
    monitor_detect <= 1'b0;
  endtask : t_monitor

  task automatic t_brownout;
    // mode still holds brownout reset enable from t_mode
    @(posedge clk);
    brownout_detect <= 1'b1;
    wait_n(2);
    chk1("core_reset_n", 1'b0, core_reset_n);
    @(posedge clk);
    brownout_detect <= 1'b0;
    wr(OFF_MODE, 32'ha500_0000);
    @(posedge clk);
    brownout_detect <= 1'b1;
    wait_n(2);
    chk1("core_reset_n", 1'b1, core_reset_n);
    @(posedge clk);
    brownout_detect <= 1'b0;
    wr(OFF_IRQ_STAT, 32'h0000_0003);
  endtask : t_brownout

  task automatic t_wake;
    int p;
    for (int e = 1; e >= 0; e--)
    begin
      wr(OFF_WUMODE, {30'h0, e[0], 1'b0});
      p = 0;
      @(posedge clk);
      monitor_detect <= 1'b1;
      repeat (6)
      begin
        @(negedge clk);
        if (monitor_wake === 1'b1) p++;
      end
      chk32("wake pulses", e, p);
      @(posedge clk);
      monitor_detect <= 1'b0;
    end
  endtask : t_wake

  // slow_tick is high every cycle, so one period is one clock
  task automatic t_duty;
    int win [6] = '{64, 64, 64, 512, 4096, 64};
    int ex [6] = '{0, 64, 2, 2, 2, 0};
    int c;
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_SMCFG, {21'h0, i[2:0], 8'h00});
      c = 0;
      repeat (win[i])
      begin
        @(negedge clk);
        if (monitor_enable === 1'b1) c++;
      end
      chk32("duty count", ex[i], c);
    end
    wr(OFF_SMCFG, 32'h0000_0200);
    wait_n(8);
    wr(OFF_SMCFG, 32'h0000_0200);
    c = 0;
    repeat (16)
    begin
      @(negedge clk);
      if (monitor_enable === 1'b1) c++;
    end
    chk32("duty restart", 1, c);
    // without a slow tick the counter must not move
    @(posedge clk);
    slow_tick <= 1'b0;
    wr(OFF_SMCFG, 32'h0000_0200);
    c = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (monitor_enable === 1'b1) c++;
    end
    chk32("duty frozen", 40, c);
    @(posedge clk);
    slow_tick <= 1'b1;
  endtask : t_duty

  // one-way commands, kept for the end of the run
  task automatic t_command;
    wr(OFF_CMD, 32'ha500_0000);
    wait_n(2);
    chk1("slow_xtal_sel", 1'b0, slow_xtal_sel);
    chk1("regulator_off", 1'b0, regulator_off);
    wr(OFF_CMD, 32'h5a00_000c);
    wait_n(3);
    chk1("slow_xtal_sel", 1'b0, slow_xtal_sel);
    chk1("regulator_off", 1'b0, regulator_off);
    wr(OFF_CMD, 32'ha500_0008);
    wait_n(1);
    chk1("slow_xtal_sel", 1'b1, slow_xtal_sel);
    rd_chk("command", OFF_CMD, 32'h0000_0000);
    rd_chk("status", OFF_STAT, 32'h0000_0080);
    wr(OFF_CMD, 32'ha500_0004);
    wait_n(1);
    chk1("regulator_off", 1'b0, regulator_off);
    chk1("core_reset_n", 1'b0, core_reset_n);
    wait_n(1);
    chk1("core_reset_n", 1'b0, core_reset_n);
    chk1("regulator_off", 1'b1, regulator_off);
    rd_chk("status", OFF_STAT, 32'h0000_0081);
  endtask : t_command

  // ****************************************
  // run control
  // ****************************************
  task automatic stop_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    be_sel = 4'hf;
    write_protect_enable = 1'b0;
    slow_tick = 1'b1;
    monitor_detect = 1'b0;
    brownout_detect = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_protect();
    t_mode();
    t_monitor();
    t_brownout();
    t_wake();
    t_duty();
    t_command();
    stop_test();
  end

  // whole run is near 5100 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    chk1("watchdog", 1'b0, 1'b1);
    stop_test();
  end
endmodule : tb_top
